// ---- hdl/rdm_pkg.sv ----
// constants for the relay driver operating-state controller
// assumes a 32-bit axi4-lite register bus and eight channels
package rdm_pkg;

   // channel count and default routes of the two control inputs
   localparam int unsigned NCH        = 8;
   localparam int unsigned DEF_CH_IN0 = 2;
   localparam int unsigned DEF_CH_IN1 = 3;

   // register byte offsets
   localparam logic [7:0] A_CHON  = 8'h00;
   localparam logic [7:0] A_MAP0  = 8'h04;
   localparam logic [7:0] A_MAP1  = 8'h08;
   localparam logic [7:0] A_HWCR  = 8'h0C;
   localparam logic [7:0] A_PGMAP = 8'h10;
   localparam logic [7:0] A_STAT  = 8'h14;
   localparam logic [7:0] A_INLV  = 8'h18;
   localparam logic [7:0] A_FAULT = 8'h1C;
   localparam logic [7:0] A_OSM   = 8'h20;
   localparam logic [7:0] A_OLF   = 8'h24;

   // reset values
   localparam logic [7:0] MAP0_RST  = 8'h04;
   localparam logic [7:0] MAP1_RST  = 8'h08;
   localparam logic [7:0] CHON_RST  = 8'h00;
   localparam logic [7:0] PGMAP_RST = 8'h00;

   // field positions
   localparam int unsigned HW_ACT    = 0;
   localparam int unsigned HW_RST    = 1;
   localparam int unsigned HW_PG0    = 2;
   localparam int unsigned HW_PG1    = 3;
   localparam int unsigned ST_UV     = 2;
   localparam int unsigned ST_LOP    = 3;
   localparam int unsigned ST_TER    = 4;
   localparam int unsigned OL_OFF_LO = 8;

   // bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // operating states, code is also the status mode field
   typedef enum logic [1:0] {
      RDM_IDLE     = 2'b00,
      RDM_FALLBACK = 2'b01,
      RDM_ACTIVE   = 2'b10,
      RDM_SLEEP    = 2'b11
   } rdm_mode_type;

endpackage

// ---- hdl/rdm_relay_driver_mode_control.sv ----
// operating-state controller with input routing and axi4-lite registers
// assumes supply flags arrive as clean synchronous levels
//
// Contract
// - after reset first input drives channel 2, second input channel 3
// - software may rewrite both input route maps freely
// - channel drive is or of channel-on bit, mapped pulse generators, mapped inputs
// - input level monitor shows input levels, also in fallback
// - wake low and inputs low: sleep, outputs off, registers default
// - wake low and an input high: fallback, only default channels driven
// - wake low forces channel-on, map, control and pulse-map registers to defaults
// - sleep with inputs low: bus accesses refused
// - logic supply undervoltage: bus refused, registers held default
// - main supply below undervoltage threshold: all channels off
// - band below operating threshold: on channels stay, new turn-on refused
// - idle: outputs off, registers usable, fault flags kept
// - wake high and input high or channel-on bit set: active
// - stay-active clear: idle when inputs and channel-on bits all zero
// - logic undervoltage with inputs low: active drops to idle
// - input high enters active even with both maps zero
// - fallback: reads answered, writes discarded
// - fallback entry: mode 01, undervoltage and logic-low flags set
// - transfer error reads 1 on first access after fallback entry
// - fallback: open-load flags zero, faults and monitor normal, rest default
// - turn-on from idle or sleep first passes through a state change
// - soft reset restores defaults but keeps channel fault flags
//
// The AXI4-Lite slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module rdm_relay_driver_mode_control
(
   input  wire logic                    clk,
   input  wire logic                    rst,
   input  wire logic [1:0]              control_inputs,
   input  wire logic                    wake_pin,
   input  wire logic                    vs_uv,
   input  wire logic                    vs_op_ok,
   input  wire logic                    vdd_uv,
   input  wire logic                    vdd_lop,
   input  wire logic [1:0]              pg_in,
   input  wire logic [rdm_pkg::NCH-1:0] fault_in,
   input  wire logic [rdm_pkg::NCH-1:0] ol_on_in,
   input  wire logic [rdm_pkg::NCH-1:0] ol_off_in,
   input  wire logic [7:0]              s_axi_awaddr,
   input  wire logic                    s_axi_awvalid,
   output logic                         s_axi_awready,
   input  wire logic [31:0]             s_axi_wdata,
   input  wire logic [3:0]              s_axi_wstrb,
   input  wire logic                    s_axi_wvalid,
   output logic                         s_axi_wready,
   output logic [1:0]                   s_axi_bresp,
   output logic                         s_axi_bvalid,
   input  wire logic                    s_axi_bready,
   input  wire logic [7:0]              s_axi_araddr,
   input  wire logic                    s_axi_arvalid,
   output logic                         s_axi_arready,
   output logic [31:0]                  s_axi_rdata,
   output logic [1:0]                   s_axi_rresp,
   output logic                         s_axi_rvalid,
   input  wire logic                    s_axi_rready,
   output logic [rdm_pkg::NCH-1:0]      ch_drive,
   output logic [1:0]                   op_mode
);

   ////////////////////////////////////////////////////////////////////////
   // state

   typedef struct packed {
      logic                    wake_s1;
      logic                    wake_s2;
      logic [1:0]              in_s1;
      logic [1:0]              in_s2;
      rdm_pkg::rdm_mode_type   mode;
      logic [rdm_pkg::NCH-1:0] chon;
      logic [rdm_pkg::NCH-1:0] map0;
      logic [rdm_pkg::NCH-1:0] map1;
      logic                    stay;
      logic [1:0]              pg_en;
      logic [rdm_pkg::NCH-1:0] pgmap0;
      logic [rdm_pkg::NCH-1:0] pgmap1;
      logic                    uv_f;
      logic                    lop_f;
      logic                    transfer_error_flag;
      logic [rdm_pkg::NCH-1:0] fault;
      logic [rdm_pkg::NCH-1:0] drive;
      logic                    aw_hold;
      logic [7:0]              awaddr;
      logic                    w_hold;
      logic [31:0]             wdata;
      logic [3:0]              wstrb;
      logic                    awready;
      logic                    wready;
      logic                    bvalid;
      logic [1:0]              bresp;
      logic                    arready;
      logic                    rvalid;
      logic [31:0]             rdata;
      logic [1:0]              rresp;
   } rdm_state_type;

   rdm_state_type q;
   rdm_state_type d;

   // replicate one bit across the channel width
   function automatic logic [rdm_pkg::NCH-1:0] rdm_fill(input logic b);
      rdm_fill = {rdm_pkg::NCH{b}};
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // next state

   always_comb
   begin
      logic                    wake;
      logic                    any_in;
      logic                    refused;
      logic                    rdonly;
      logic                    srst;
      logic                    wr_bad;
      logic [rdm_pkg::NCH-1:0] fclr;
      logic [rdm_pkg::NCH-1:0] req;
      wake    = 1'b0;
      any_in  = 1'b0;
      refused = 1'b0;
      rdonly  = 1'b0;
      srst    = 1'b0;
      wr_bad  = 1'b0;
      fclr    = '0;
      req     = '0;
      d       = q;

      // two-stage synchronisers
      // first stages feed only second stages, never the decision logic
      d.wake_s1 = wake_pin;
      d.wake_s2 = q.wake_s1;
      d.in_s1   = control_inputs;
      d.in_s2   = q.in_s1;
      wake      = q.wake_s2;
      any_in    = |q.in_s2;

      // operating-state decision
      if (!wake)
      begin
         if (any_in)
            d.mode = rdm_pkg::RDM_FALLBACK;
         else
            d.mode = rdm_pkg::RDM_SLEEP;
      end
      else
      begin
         unique case (q.mode)
            rdm_pkg::RDM_SLEEP,
            rdm_pkg::RDM_FALLBACK:
               d.mode = rdm_pkg::RDM_IDLE;
            rdm_pkg::RDM_IDLE:
               if (any_in || |q.chon)
                  d.mode = rdm_pkg::RDM_ACTIVE;
            rdm_pkg::RDM_ACTIVE:
               if (!any_in && (vdd_uv || (!q.stay && q.chon == '0)))
                  d.mode = rdm_pkg::RDM_IDLE;
         endcase
      end

      // access permissions
      // a refused access answers with an error and changes no register but the transfer error flag
      refused = q.mode == rdm_pkg::RDM_SLEEP || vdd_uv || (!wake && !any_in);
      rdonly  = q.mode == rdm_pkg::RDM_FALLBACK;

      // write address and data are taken in either order
      if (q.awready && s_axi_awvalid)
      begin
         d.aw_hold = 1'b1;
         d.awaddr  = s_axi_awaddr;
      end
      if (q.wready && s_axi_wvalid)
      begin
         d.w_hold = 1'b1;
         d.wdata  = s_axi_wdata;
         d.wstrb  = s_axi_wstrb;
      end

      // write execution once both halves are held
      if (q.aw_hold && q.w_hold && !q.bvalid)
      begin
         d.aw_hold = 1'b0;
         d.w_hold  = 1'b0;
         d.bvalid  = 1'b1;
         if (!refused && !rdonly)
         begin
            unique case (q.awaddr)
               rdm_pkg::A_CHON:
                  if (q.wstrb[0]) d.chon = q.wdata[7:0];
               rdm_pkg::A_MAP0:
                  if (q.wstrb[0]) d.map0 = q.wdata[7:0];
               rdm_pkg::A_MAP1:
                  if (q.wstrb[0]) d.map1 = q.wdata[7:0];
               rdm_pkg::A_HWCR:
                  if (q.wstrb[0])
                  begin
                     d.stay     = q.wdata[rdm_pkg::HW_ACT];
                     d.pg_en[0] = q.wdata[rdm_pkg::HW_PG0];
                     d.pg_en[1] = q.wdata[rdm_pkg::HW_PG1];
                     srst       = q.wdata[rdm_pkg::HW_RST];
                  end
               rdm_pkg::A_PGMAP:
               begin
                  if (q.wstrb[0]) d.pgmap0 = q.wdata[7:0];
                  if (q.wstrb[1]) d.pgmap1 = q.wdata[15:8];
               end
               rdm_pkg::A_FAULT:
                  if (q.wstrb[0]) fclr = q.wdata[7:0];
               rdm_pkg::A_STAT,
               rdm_pkg::A_INLV,
               rdm_pkg::A_OSM,
               rdm_pkg::A_OLF: ;
               default:
                  wr_bad = 1'b1;
            endcase
         end
         else
            wr_bad = 1'b1;
         d.bresp = wr_bad ? rdm_pkg::RESP_SLVERR : rdm_pkg::RESP_OKAY;
         d.transfer_error_flag   = wr_bad;
      end
      if (q.bvalid && s_axi_bready)
         d.bvalid = 1'b0;
      d.awready = !d.aw_hold && !d.bvalid;
      d.wready  = !d.w_hold && !d.bvalid;

      // read execution
      if (q.arready && s_axi_arvalid)
      begin
         d.rvalid = 1'b1;
         d.rdata  = '0;
         d.rresp  = rdm_pkg::RESP_OKAY;
         d.transfer_error_flag    = refused;
         if (refused)
            d.rresp = rdm_pkg::RESP_SLVERR;
         else
         begin
            unique case (s_axi_araddr)
               rdm_pkg::A_CHON:  d.rdata[7:0] = q.chon;
               rdm_pkg::A_MAP0:  d.rdata[7:0] = q.map0;
               rdm_pkg::A_MAP1:  d.rdata[7:0] = q.map1;
               rdm_pkg::A_HWCR:
               begin
                  d.rdata[rdm_pkg::HW_ACT] = q.stay;
                  d.rdata[rdm_pkg::HW_PG0] = q.pg_en[0];
                  d.rdata[rdm_pkg::HW_PG1] = q.pg_en[1];
               end
               rdm_pkg::A_PGMAP: d.rdata[15:0] = {q.pgmap1, q.pgmap0};
               rdm_pkg::A_STAT:
               begin
                  d.rdata[1:0]            = q.mode;
                  d.rdata[rdm_pkg::ST_UV]  = q.uv_f;
                  d.rdata[rdm_pkg::ST_LOP] = q.lop_f;
                  d.rdata[rdm_pkg::ST_TER] = q.transfer_error_flag;
                  // readout clears flags whose condition is gone
                  if (!vs_uv) d.uv_f = 1'b0;
                  if (!vdd_lop) d.lop_f = 1'b0;
               end
               rdm_pkg::A_INLV:  d.rdata[1:0] = q.in_s2;
               rdm_pkg::A_FAULT: d.rdata[7:0] = q.fault;
               rdm_pkg::A_OSM:   d.rdata[7:0] = q.drive;
               rdm_pkg::A_OLF:
                  if (!rdonly)
                     d.rdata[15:0] = {ol_off_in, ol_on_in};
               default:
                  d.rresp = rdm_pkg::RESP_SLVERR;
            endcase
         end
      end
      if (q.rvalid && s_axi_rready)
         d.rvalid = 1'b0;
      d.arready = !d.rvalid;

      // forced defaults by wake low, logic undervoltage, fallback, soft reset
      if (!wake || vdd_uv || rdonly || srst)
      begin
         d.chon   = rdm_pkg::CHON_RST;
         d.map0   = rdm_pkg::MAP0_RST;
         d.map1   = rdm_pkg::MAP1_RST;
         d.stay   = 1'b0;
         d.pg_en  = 2'b00;
         d.pgmap0 = rdm_pkg::PGMAP_RST;
         d.pgmap1 = rdm_pkg::PGMAP_RST;
      end
      if (srst)
      begin
         d.uv_f  = 1'b0;
         d.lop_f = 1'b0;
         d.transfer_error_flag   = 1'b0;
      end

      // fault flags: sticky, set wins, kept in idle and over soft reset
      d.fault = (q.fault & ~fclr) | fault_in;
      if (q.mode == rdm_pkg::RDM_SLEEP)
         d.fault = '0;

      // supply flags, set wins over clear
      if (vs_uv) d.uv_f = 1'b1;
      if (vdd_lop) d.lop_f = 1'b1;
      if (d.mode == rdm_pkg::RDM_FALLBACK)
      begin
         d.uv_f  = 1'b1;
         d.lop_f = 1'b1;
      end
      if (d.mode == rdm_pkg::RDM_FALLBACK && q.mode != rdm_pkg::RDM_FALLBACK)
         d.transfer_error_flag = 1'b1;

      // channel request per state
      // idle and sleep request nothing, whatever the registers hold
      unique case (q.mode)
         rdm_pkg::RDM_ACTIVE:
            req = q.chon
                | (rdm_fill(q.pg_en[0] & pg_in[0]) & q.pgmap0)
                | (rdm_fill(q.pg_en[1] & pg_in[1]) & q.pgmap1)
                | (rdm_fill(q.in_s2[0]) & q.map0)
                | (rdm_fill(q.in_s2[1]) & q.map1);
         rdm_pkg::RDM_FALLBACK:
         begin
            req[rdm_pkg::DEF_CH_IN0] = q.in_s2[0];
            req[rdm_pkg::DEF_CH_IN1] = q.in_s2[1];
         end
         rdm_pkg::RDM_IDLE,
         rdm_pkg::RDM_SLEEP:
            req = '0;
      endcase

      // main supply gating
      // between thresholds a channel may hold its state but never newly turn on
      if (vs_uv)
         d.drive = '0;
      else if (!vs_op_ok)
         d.drive = req & q.drive;
      else
         d.drive = req;
   end

   ////////////////////////////////////////////////////////////////////////
   // registers

   // reset leaves the block asleep with the default input routes
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         q      <= '0;
         q.mode <= rdm_pkg::RDM_SLEEP;
         q.map0 <= rdm_pkg::MAP0_RST;
         q.map1 <= rdm_pkg::MAP1_RST;
      end
      else
         q <= d;
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs straight from flops

   assign s_axi_awready = q.awready;
   assign s_axi_wready  = q.wready;
   assign s_axi_bresp   = q.bresp;
   assign s_axi_bvalid  = q.bvalid;
   assign s_axi_arready = q.arready;
   assign s_axi_rdata   = q.rdata;
   assign s_axi_rresp   = q.rresp;
   assign s_axi_rvalid  = q.rvalid;
   assign ch_drive      = q.drive;
   assign op_mode       = q.mode;

endmodule

// ---- dv/rdm_chk.sv ----
// checker: mode, channel and bus refusal relations of the mode controller
// assumes one clock domain with an active-high reset
`timescale 1ns/1ps
module rdm_chk
(
   input wire logic        clk,
   input wire logic        rst,
   input wire logic [1:0]  control_inputs,
   input wire logic        wake_pin,
   input wire logic        vs_uv,
   input wire logic        vdd_uv,
   input wire logic        s_axi_bvalid,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_rvalid,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [7:0]  ch_drive,
   input wire logic [1:0]  op_mode
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);
   ////////////////////////////////////////
   // mode entry, with room for the input synchronisers
   property p_sleep_entry;
      (!wake_pin && control_inputs == 2'h0) [*8] |-> op_mode == rdm_pkg::RDM_SLEEP;
   endproperty
   a_sleep_entry: assert property (p_sleep_entry)
      else $error("sleep not entered");
   property p_limp_entry;
      (!wake_pin && control_inputs != 2'h0) [*8] |-> op_mode == rdm_pkg::RDM_FALLBACK;
   endproperty
   a_limp_entry: assert property (p_limp_entry)
      else $error("fallback not entered");
   property p_active_entry;
      (wake_pin && control_inputs != 2'h0) [*8] |-> op_mode == rdm_pkg::RDM_ACTIVE;
   endproperty
   a_active_entry: assert property (p_active_entry)
      else $error("active not entered");
   ////////////////////////////////////////
   // outputs of a settled mode, drive lags state by one edge
   property p_sleep_off;
      (op_mode == rdm_pkg::RDM_SLEEP) [*2] |-> ch_drive == 8'h00;
   endproperty
   a_sleep_off: assert property (p_sleep_off)
      else $error("channel on in sleep");
   property p_idle_off;
      (op_mode == rdm_pkg::RDM_IDLE) [*2] |-> ch_drive == 8'h00;
   endproperty
   a_idle_off: assert property (p_idle_off)
      else $error("channel on in idle");
   property p_limp_chan;
      (op_mode == rdm_pkg::RDM_FALLBACK) [*2] |-> (ch_drive & 8'hF3) == 8'h00;
   endproperty
   a_limp_chan: assert property (p_limp_chan)
      else $error("non-default channel on in fallback");
   property p_vs_off;
      vs_uv [*3] |-> ch_drive == 8'h00;
   endproperty
   a_vs_off: assert property (p_vs_off)
      else $error("channel on under supply undervoltage");
   ////////////////////////////////////////
   // bus refusals
   property p_sleep_refuse;
      $rose(s_axi_rvalid) && op_mode == rdm_pkg::RDM_SLEEP
      && $past(op_mode) == rdm_pkg::RDM_SLEEP && $past(op_mode, 2) == rdm_pkg::RDM_SLEEP
      |-> s_axi_rresp == rdm_pkg::RESP_SLVERR && s_axi_rdata == 32'h0;
   endproperty
   a_sleep_refuse: assert property (p_sleep_refuse)
      else $error("read answered in sleep");
   property p_limp_write;
      $rose(s_axi_bvalid) && op_mode == rdm_pkg::RDM_FALLBACK
      && $past(op_mode) == rdm_pkg::RDM_FALLBACK && $past(op_mode, 2) == rdm_pkg::RDM_FALLBACK
      |-> s_axi_bresp == rdm_pkg::RESP_SLVERR;
   endproperty
   a_limp_write: assert property (p_limp_write)
      else $error("write accepted in fallback");
   property p_vdd_refuse;
      $rose(s_axi_bvalid) && vdd_uv && $past(vdd_uv) && $past(vdd_uv, 2)
      |-> s_axi_bresp == rdm_pkg::RESP_SLVERR;
   endproperty
   a_vdd_refuse: assert property (p_vdd_refuse)
      else $error("write accepted under logic undervoltage");
endmodule
bind rdm_relay_driver_mode_control rdm_chk chk_u (.*);

// ---- dv/rdm_mcu.sv ----
// microcontroller model: axi4-lite master and control pin driver
// assumes the bench calls one task at a time, after reset
`timescale 1ns/1ps
module rdm_mcu
#(
   parameter int HOLD = 12
)
(
   input  wire logic        clk,
   output logic [7:0]       s_axi_awaddr,
   output logic             s_axi_awvalid,
   input  wire logic        s_axi_awready,
   output logic [31:0]      s_axi_wdata,
   output logic [3:0]       s_axi_wstrb,
   output logic             s_axi_wvalid,
   input  wire logic        s_axi_wready,
   input  wire logic [1:0]  s_axi_bresp,
   input  wire logic        s_axi_bvalid,
   output logic             s_axi_bready,
   output logic [7:0]       s_axi_araddr,
   output logic             s_axi_arvalid,
   input  wire logic        s_axi_arready,
   input  wire logic [31:0] s_axi_rdata,
   input  wire logic [1:0]  s_axi_rresp,
   input  wire logic        s_axi_rvalid,
   output logic             s_axi_rready,
   output logic [1:0]       control_inputs,
   output logic             wake_pin
);
   // idle bus and pins at time zero
   initial
   begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_araddr, s_axi_arvalid, s_axi_rready, control_inputs, wake_pin} = '0;
      s_axi_wstrb = 4'hF;
   end
   ////////////////////////////////////////
   // one write, channels released as taken, payload scrambled after
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      bit aw;
      bit w;
      aw = 1'b0;
      w = 1'b0;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw && w))
      begin
         @(posedge clk);
         if (!aw && s_axi_awready)
         begin
            aw = 1'b1;
            s_axi_awvalid <= 1'b0;
            s_axi_awaddr <= ~a;
         end
         if (!w && s_axi_wready)
         begin
            w = 1'b1;
            s_axi_wvalid <= 1'b0;
            s_axi_wdata <= ~d;
         end
      end
      while (!s_axi_bvalid)
         @(posedge clk);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   // one read, rready held until the answer is sampled
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge clk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      s_axi_araddr <= ~a;
      do @(posedge clk); while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   // pins change together and then hold for the minimum time
   task automatic pins(input logic w, input logic [1:0] i);
      @(posedge clk);
      wake_pin <= w;
      control_inputs <= i;
      repeat (HOLD) @(posedge clk);
   endtask
endmodule

// ---- dv/rdm_relay_driver_mode_control_tb_top.sv ----
// testbench: mode controller driven by the microcontroller model
// assumes package, design, model and bound checker compiled before it
`timescale 1ns/1ps
module rdm_relay_driver_mode_control_tb_top;
   logic        clk, rst, wake_pin, vs_uv, vs_op_ok, vdd_uv, vdd_lop;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bready;
   logic        s_axi_bvalid, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [1:0]  control_inputs, pg_in, s_axi_bresp, s_axi_rresp, op_mode;
   logic [3:0]  s_axi_wstrb;
   logic [7:0]  fault_in, ol_on_in, ol_off_in, ch_drive, s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   int          error_cnt = 0;
   int          n_compared = 0;
   rdm_relay_driver_mode_control dut_u (.*);
   rdm_mcu mcu_u (.*);
   // free-running clock, 8 ns period
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   ////////////////////////////////////////
   task automatic complete_run;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_compared++;
      if (s !== e)
      begin
         error_cnt++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   // settled mode and channel drive
   task automatic st(input logic [1:0] m, input logic [7:0] c);
      repeat (6) @(negedge clk);
      chk({30'h0, op_mode}, {30'h0, m});
      chk({24'h0, ch_drive}, {24'h0, c});
   endtask
   task automatic wrc(input logic [7:0] a, input logic [31:0] d, input bit bad);
      logic [1:0] r;
      mcu_u.wr(a, d, r);
      chk({30'h0, r}, {30'h0, bad ? rdm_pkg::RESP_SLVERR : rdm_pkg::RESP_OKAY});
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e, input bit bad);
      logic [31:0] d;
      logic [1:0]  r;
      mcu_u.rd(a, d, r);
      chk(d, e);
      chk({30'h0, r}, {30'h0, bad ? rdm_pkg::RESP_SLVERR : rdm_pkg::RESP_OKAY});
   endtask
   task automatic sup(input logic u, input logic k, input logic v);
      @(posedge clk);
      vs_uv <= u;
      vs_op_ok <= k;
      vdd_uv <= v;
   endtask
   ////////////////////////////////////////
   task automatic t_defaults;
      mcu_u.pins(1'b1, 2'b00);
      st(rdm_pkg::RDM_IDLE, 8'h00);
      rdc(rdm_pkg::A_MAP0, 32'h04, 1'b0);
      rdc(rdm_pkg::A_MAP1, 32'h08, 1'b0);
      wrc(8'h28, 32'h01, 1'b1);
      mcu_u.pins(1'b1, 2'b01);
      st(rdm_pkg::RDM_ACTIVE, 8'h04);
      mcu_u.pins(1'b1, 2'b10);
      st(rdm_pkg::RDM_ACTIVE, 8'h08);
      rdc(rdm_pkg::A_INLV, 32'h02, 1'b0);
      $display("test defaults done");
   endtask
   task automatic t_route;
      mcu_u.pins(1'b1, 2'b01);
      wrc(rdm_pkg::A_MAP0, 32'h81, 1'b0);
      st(rdm_pkg::RDM_ACTIVE, 8'h81);
      wrc(rdm_pkg::A_PGMAP, 32'h10, 1'b0);
      wrc(rdm_pkg::A_HWCR, 32'h04, 1'b0);
      @(posedge clk);
      pg_in <= 2'b01;
      fault_in <= 8'h02;
      @(posedge clk);
      fault_in <= 8'h00;
      wrc(rdm_pkg::A_CHON, 32'h40, 1'b0);
      st(rdm_pkg::RDM_ACTIVE, 8'hD1);
      mcu_u.pins(1'b1, 2'b00);
      st(rdm_pkg::RDM_ACTIVE, 8'h50);
      wrc(rdm_pkg::A_CHON, 32'h00, 1'b0);
      st(rdm_pkg::RDM_IDLE, 8'h00);
      wrc(rdm_pkg::A_CHON, 32'h20, 1'b0);
      st(rdm_pkg::RDM_ACTIVE, 8'h30);
      wrc(rdm_pkg::A_HWCR, 32'h05, 1'b0);
      wrc(rdm_pkg::A_CHON, 32'h00, 1'b0);
      st(rdm_pkg::RDM_ACTIVE, 8'h10);
      wrc(rdm_pkg::A_HWCR, 32'h02, 1'b0);
      st(rdm_pkg::RDM_IDLE, 8'h00);
      rdc(rdm_pkg::A_FAULT, 32'h02, 1'b0);
      rdc(rdm_pkg::A_MAP0, 32'h04, 1'b0);
      pg_in <= 2'b00;
      $display("test route done");
   endtask
   task automatic t_zero_maps;
      wrc(rdm_pkg::A_MAP0, 32'h00, 1'b0);
      wrc(rdm_pkg::A_MAP1, 32'h00, 1'b0);
      mcu_u.pins(1'b1, 2'b10);
      st(rdm_pkg::RDM_ACTIVE, 8'h00);
      mcu_u.pins(1'b1, 2'b00);
      st(rdm_pkg::RDM_IDLE, 8'h00);
      $display("test zero maps done");
   endtask
   task automatic t_limp;
      wrc(rdm_pkg::A_MAP0, 32'h10, 1'b0);
      ol_on_in <= 8'hFF;
      ol_off_in <= 8'h5A;
      rdc(rdm_pkg::A_OLF, 32'h5AFF, 1'b0);
      mcu_u.pins(1'b0, 2'b01);
      st(rdm_pkg::RDM_FALLBACK, 8'h04);
      rdc(rdm_pkg::A_STAT, 32'h1D, 1'b0);
      rdc(rdm_pkg::A_INLV, 32'h01, 1'b0);
      rdc(rdm_pkg::A_MAP0, 32'h04, 1'b0);
      wrc(rdm_pkg::A_CHON, 32'h01, 1'b1);
      rdc(rdm_pkg::A_CHON, 32'h00, 1'b0);
      rdc(rdm_pkg::A_OLF, 32'h00, 1'b0);
      mcu_u.pins(1'b0, 2'b11);
      st(rdm_pkg::RDM_FALLBACK, 8'h0C);
      rdc(rdm_pkg::A_OSM, 32'h0C, 1'b0);
      ol_on_in <= 8'h00;
      ol_off_in <= 8'h00;
      $display("test fallback done");
   endtask
   task automatic t_sleep;
      mcu_u.pins(1'b0, 2'b00);
      st(rdm_pkg::RDM_SLEEP, 8'h00);
      rdc(rdm_pkg::A_MAP0, 32'h00, 1'b1);
      mcu_u.pins(1'b1, 2'b00);
      st(rdm_pkg::RDM_IDLE, 8'h00);
      $display("test sleep done");
   endtask
   task automatic t_supply;
      wrc(rdm_pkg::A_CHON, 32'h01, 1'b0);
      st(rdm_pkg::RDM_ACTIVE, 8'h01);
      sup(1'b1, 1'b0, 1'b0);
      st(rdm_pkg::RDM_ACTIVE, 8'h00);
      sup(1'b0, 1'b1, 1'b0);
      st(rdm_pkg::RDM_ACTIVE, 8'h01);
      sup(1'b0, 1'b0, 1'b0);
      wrc(rdm_pkg::A_CHON, 32'h03, 1'b0);
      st(rdm_pkg::RDM_ACTIVE, 8'h01);
      sup(1'b0, 1'b1, 1'b1);
      st(rdm_pkg::RDM_IDLE, 8'h00);
      wrc(rdm_pkg::A_CHON, 32'h01, 1'b1);
      sup(1'b0, 1'b1, 1'b0);
      rdc(rdm_pkg::A_CHON, 32'h00, 1'b0);
      $display("test supply done");
   endtask
   ////////////////////////////////////////
   // reset, then the scenarios in order
   initial
   begin
      rst = 1'b1;
      vs_op_ok = 1'b1;
      {vs_uv, vdd_uv, vdd_lop, pg_in, fault_in, ol_on_in, ol_off_in} = '0;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      t_defaults();
      t_route();
      t_zero_maps();
      t_limp();
      t_sleep();
      t_supply();
      complete_run();
   end
   // watchdog against a hung handshake
   initial
   begin
      #400us;
      error_cnt++;
      complete_run();
   end
endmodule
